// file: hdl/nvm_page_map.vh
// Register map, field positions and timing counts of the page erase/write control
`ifndef NVM_PAGE_MAP_VH
`define NVM_PAGE_MAP_VH

// Register indices; byte address is four times the index
`define NVM_IDX_CACHE_BASE   10'h000
`define NVM_CACHE_BYTES      8
`define NVM_IDX_PAGE_SELECT  10'h088
`define NVM_IDX_COMMAND      10'h089
`define NVM_IDX_STATUS       10'h08B
`define NVM_IDX_LOCK_VIEW    10'h090

// Page select field
`define NVM_PAGE_MSB         3
// Command fields
`define NVM_CMD_PROGRAM      0
`define NVM_CMD_ERASE        1
`define NVM_CMD_ERASE_PROG   2
`define NVM_CMD_TIMING       3
// Status fields
`define NVM_ST_READ          0
`define NVM_ST_ERASE         1
`define NVM_ST_PROGRAM       2

// Reset values
`define NVM_PAGE_RESET       8'h00
`define NVM_CMD_RESET        8'h00

// Lock bit home inside the array
`define NVM_LOCK_PAGE        4'h8
`define NVM_LOCK_BYTE        3'h5
`define NVM_LOCK_BIT         0

// Timing
`define NVM_OP_TIME_MS       8
`define NVM_CLK_KHZ          40000
`define NVM_FIXED_CYC        (`NVM_OP_TIME_MS * `NVM_CLK_KHZ)

`endif

// file: hdl/nvm_page_erase_write_control.v
// Page erase/write sequencer for a nonvolatile array with a Wishbone register file
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "nvm_page_map.vh"

module nvm_page_erase_write_control #(
  parameter [18:0] FIXED_CYCLES   = `NVM_FIXED_CYC,
  parameter [18:0] VAR_MAX_CYCLES = `NVM_FIXED_CYC - 1
) (
  input  wire        clock,
  input  wire        rst_n,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [11:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg  [3:0]  mem_page,
  output reg  [2:0]  mem_byte,
  output reg  [7:0]  mem_wdata,
  output reg         mem_load,
  output reg         mem_prog,
  output reg         mem_erase,
  output reg         mem_read,
  input  wire [7:0]  mem_rdata,
  input  wire        mem_ready
);

  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_ERASE = 3'd1;
  localparam [2:0] ST_LOAD  = 3'd2;
  localparam [2:0] ST_PROG  = 3'd3;
  localparam [2:0] ST_READ  = 3'd4;
  localparam [2:0] ST_CAP   = 3'd5;
  localparam [2:0] ST_TAKE  = 3'd6;

  reg  [7:0]  cache [0:`NVM_CACHE_BYTES-1];
  reg  [7:0]  page_select;
  reg  [7:0]  command;
  reg  [2:0]  status;
  reg         lock;
  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [18:0] tmr;
  reg  [2:0]  ld_idx;
  reg         then_prog;
  reg  [3:0]  op_page;
  reg  [31:0] next_dat;
  wire [9:0]  idx;
  wire        bus_req;
  wire        wr_en;
  wire        cmd_wr;
  wire        start_ok;
  wire        op_end;
  wire        is_cache;
  integer     i;

  assign idx      = wb_adr_i[11:2];
  assign bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en    = bus_req & wb_we_i & wb_sel_i[0];
  assign cmd_wr   = wr_en & (idx == `NVM_IDX_COMMAND);
  assign start_ok = cmd_wr & ~lock & (state == ST_IDLE);
  assign is_cache = (idx < `NVM_CACHE_BYTES);
  // Fixed mode runs the full time; variable ends on array ready, capped
  assign op_end   = command[`NVM_CMD_TIMING] ? (tmr == FIXED_CYCLES - 19'd1) :
                    (mem_ready | (tmr == VAR_MAX_CYCLES - 19'd1));

  // Sequencer next state
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_ok) begin
          if (wb_dat_i[`NVM_CMD_ERASE_PROG] | wb_dat_i[`NVM_CMD_ERASE])
            next_state = ST_ERASE;
          else if (wb_dat_i[`NVM_CMD_PROGRAM])
            next_state = ST_LOAD;
        end
      end
      ST_ERASE: begin
        if (op_end)
          next_state = then_prog ? ST_LOAD : ST_READ;
      end
      ST_LOAD: begin
        if (ld_idx == 3'd7)
          next_state = ST_PROG;
      end
      ST_PROG: begin
        if (op_end)
          next_state = ST_READ;
      end
      ST_READ: next_state = ST_CAP;
      // Array answers the read one cycle after the pulse
      ST_CAP:  next_state = ST_TAKE;
      ST_TAKE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // Sequencer state, timer and array drive
  always @(posedge clock) begin
    if (!rst_n) begin
      state     <= ST_READ;
      tmr       <= 19'd0;
      ld_idx    <= 3'd0;
      then_prog <= 1'b0;
      op_page   <= 4'h0;
      lock      <= 1'b1;
      status    <= 3'b000;
      mem_page  <= 4'h0;
      mem_byte  <= 3'd0;
      mem_wdata <= 8'h00;
      mem_load  <= 1'b0;
      mem_prog  <= 1'b0;
      mem_erase <= 1'b0;
      mem_read  <= 1'b0;
    end else begin
      state    <= next_state;
      mem_load <= 1'b0;
      mem_read <= 1'b0;
      tmr      <= (state == next_state) ? tmr + 19'd1 : 19'd0;
      if (start_ok) begin
        op_page   <= page_select[`NVM_PAGE_MSB:0];
        then_prog <= wb_dat_i[`NVM_CMD_ERASE_PROG];
      end
      case (next_state)
        ST_ERASE: begin
          mem_page  <= (state == ST_IDLE) ? page_select[`NVM_PAGE_MSB:0] : op_page;
          mem_erase <= 1'b1;
          mem_prog  <= 1'b0;
          status    <= 3'b010;
        end
        ST_LOAD: begin
          if (state == ST_IDLE)
            mem_page <= page_select[`NVM_PAGE_MSB:0];
          mem_erase <= 1'b0;
          mem_load  <= 1'b1;
          mem_byte  <= (state == ST_LOAD) ? ld_idx + 3'd1 : 3'd0;
          mem_wdata <= cache[(state == ST_LOAD) ? ld_idx + 3'd1 : 3'd0];
          ld_idx    <= (state == ST_LOAD) ? ld_idx + 3'd1 : 3'd0;
          status    <= 3'b100;
        end
        ST_PROG: begin
          mem_prog <= 1'b1;
          status   <= 3'b100;
        end
        ST_READ: begin
          mem_erase <= 1'b0;
          mem_prog  <= 1'b0;
          status    <= 3'b001;
        end
        ST_CAP: begin
          // Refetch the lock byte from its home in the array
          mem_page <= `NVM_LOCK_PAGE;
          mem_byte <= `NVM_LOCK_BYTE;
          mem_read <= 1'b1;
          status   <= 3'b001;
        end
        ST_TAKE: begin
          status   <= 3'b001;
        end
        default: begin
          mem_erase <= 1'b0;
          mem_prog  <= 1'b0;
          status    <= 3'b000;
        end
      endcase
      if (state == ST_TAKE)
        lock <= mem_rdata[`NVM_LOCK_BIT];
    end
  end

  // Register writes
  always @(posedge clock) begin
    if (!rst_n) begin
      page_select <= `NVM_PAGE_RESET;
      command     <= `NVM_CMD_RESET;
      for (i = 0; i < `NVM_CACHE_BYTES; i = i + 1)
        cache[i] <= 8'h00;
    end else begin
      if (wr_en & (idx == `NVM_IDX_PAGE_SELECT))
        page_select <= wb_dat_i[7:0];
      // Self-clear at op end even if a command write lands that cycle
      if ((state != ST_IDLE) & (next_state == ST_READ))
        command[2:0] <= 3'b000;
      if (cmd_wr) begin
        command[`NVM_CMD_TIMING] <= wb_dat_i[`NVM_CMD_TIMING];
        command[7:4]             <= wb_dat_i[7:4];
        if (start_ok)
          command[2:0] <= wb_dat_i[2:0];
      end
      if (wr_en & is_cache)
        cache[idx[2:0]] <= wb_dat_i[7:0];
    end
  end

  // Read data mux
  always @* begin
    next_dat = 32'h0000_0000;
    if (is_cache)
      next_dat[7:0] = cache[idx[2:0]];
    else if (idx == `NVM_IDX_PAGE_SELECT)
      next_dat[7:0] = page_select;
    else if (idx == `NVM_IDX_COMMAND)
      next_dat[7:0] = command;
    else if (idx == `NVM_IDX_STATUS)
      next_dat[2:0] = status;
    else if (idx == `NVM_IDX_LOCK_VIEW)
      next_dat[0] = lock;
  end

  // Wishbone answer one cycle after the request
  always @(posedge clock) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? next_dat : 32'h0000_0000;
    end
  end

endmodule // nvm_page_erase_write_control
`default_nettype wire

// file: verif/nvm_array_model.sv
// Array and page cache model
`timescale 1ns/1ps
`default_nettype none
module nvm_array_model (
  input  wire        clock,
  input  wire [3:0]  mem_page,
  input  wire [2:0]  mem_byte,
  input  wire [7:0]  mem_wdata,
  input  wire        mem_load,
  input  wire        mem_prog,
  input  wire        mem_erase,
  input  wire        mem_read,
  output logic [7:0] mem_rdata,
  output logic       mem_ready
);
  logic [7:0] cells [0:127] = '{default: 8'h00};
  logic [7:0] cache [0:7];
  logic [2:0] busy;
  always @(posedge clock) begin
    if (mem_load) cache[mem_byte] <= mem_wdata;
    for (int i = 0; i < 8; i++) begin
      if (mem_erase) cells[{mem_page, 3'(i)}] <= 8'h00;
      if (mem_prog) cells[{mem_page, 3'(i)}] <= cache[i];
    end
    mem_rdata <= mem_read ? cells[{mem_page, mem_byte}] : ~mem_rdata;
    busy <= (mem_prog || mem_erase) ? busy + 3'h1 : 3'h0;
    mem_ready <= busy == 3'h3;
  end
endmodule // nvm_array_model
`default_nettype wire

// file: verif/nvm_page_erase_write_control_asserts.sv
// Port assertions of the page erase/write control
`timescale 1ns/1ps
`default_nettype none
module nvm_pewc_asserts #(
  parameter int FIXED_CYCLES = 40
) (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic [3:0]  mem_page,
  input wire logic [2:0]  mem_byte,
  input wire logic        mem_load,
  input wire logic        mem_prog,
  input wire logic        mem_erase,
  input wire logic        mem_read
);
  int len;
  always @(posedge clock)
    if (!rst_n || !(mem_prog || mem_erase)) len <= 0;
    else len <= len + 1;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data outside ack");
  a_prog_after_loads: assert property ($rose(mem_prog) |-> $past(mem_load) &&
    $past(mem_byte) == 3'h7 && $past(mem_load, 8) && $past(mem_byte, 8) == 3'h0)
    else $error("program without loads");
  a_erase_prog_apart: assert property (!(mem_prog && mem_erase))
    else $error("erase and program overlap");
  a_lock_fetch: assert property (mem_read |-> mem_page == 4'h8 && mem_byte == 3'h5)
    else $error("read off lock byte");
  a_read_pulse: assert property (mem_read |=> !mem_read)
    else $error("read too long");
  a_op_bound: assert property (len <= FIXED_CYCLES)
    else $error("operation too long");
  cover property ($rose(mem_prog));
  cover property ($rose(mem_erase));
  cover property (mem_read);
endmodule // nvm_pewc_asserts
bind nvm_page_erase_write_control nvm_pewc_asserts #(.FIXED_CYCLES(FIXED_CYCLES)) chk (
  .clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o,
  .mem_page, .mem_byte, .mem_load, .mem_prog, .mem_erase, .mem_read);
`default_nettype wire

// file: verif/tb_nvm_page_erase_write_control.sv
// Testbench for the page erase/write control
`timescale 1ns/1ps
`default_nettype none
module tb_nvm_page_erase_write_control;
  logic        clock = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [3:0]  wb_sel_i = 4'hF, mem_page;
  logic [11:0] wb_adr_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, d;
  logic        wb_ack_o, mem_load, mem_prog, mem_erase, mem_read, mem_ready;
  logic [2:0]  mem_byte;
  logic [7:0]  mem_wdata, mem_rdata;
  int          failures = 0, samples_checked = 0, run = 0, last_run = 0, i;
  nvm_page_erase_write_control #(.FIXED_CYCLES(19'd40), .VAR_MAX_CYCLES(19'd39)) dut (.*);
  nvm_array_model arr (.*);
  initial forever #12.5 clock = ~clock;
  always @(posedge clock)
    if (mem_prog || mem_erase) run <= run + 1;
    else begin
      if (run != 0) last_run <= run;
      run <= 0;
    end
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic op(input logic we, input logic [9:0] idx, input logic [7:0] wd);
    @(posedge clock);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, idx, 2'b00, 24'h0, wd};
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    d = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic rd(input logic [9:0] idx, input logic [31:0] e);
    op(0, idx, 8'h00);
    check(d, e);
  endtask
  task automatic idle;
    do op(0, 10'h08B, 8'h00); while (d !== 32'h0);
  endtask
  task automatic page3(input logic [7:0] base);
    for (i = 0; i < 8; i++) check(arr.cells[{4'h3, 3'(i)}], base == 0 ? 0 : base + i);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1;
    idle();
    rd(10'h088, 0);
    rd(10'h089, 0);
    rd(10'h090, 0);
    op(1, 10'h08B, 8'hFF);
    rd(10'h08B, 0);
    rd(10'h0A0, 0);
    op(1, 10'h088, 8'h03);
    rd(10'h088, 3);
    for (i = 0; i < 8; i++) op(1, 10'(i), 8'hA0 + 8'(i));
    $display("test registers done");
    op(1, 10'h089, 8'h09);
    rd(10'h08B, 4);
    idle();
    check(last_run, 40);
    rd(10'h089, 8);
    page3(8'hA0);
    op(1, 10'h089, 8'h0A);
    rd(10'h08B, 2);
    idle();
    check(last_run, 40);
    page3(8'h00);
    op(1, 10'h089, 8'h04);
    idle();
    check(last_run < 40, 1);
    page3(8'hA0);
    $display("test operations done");
    op(1, 10'h088, 8'h08);
    for (i = 0; i < 8; i++) op(1, 10'(i), (i == 5) ? 8'h01 : 8'h00);
    op(1, 10'h089, 8'h01);
    idle();
    rd(10'h090, 1);
    op(1, 10'h088, 8'h03);
    op(1, 10'h089, 8'h02);
    rd(10'h08B, 0);
    rd(10'h089, 0);
    page3(8'hA0);
    $display("test lock done");
    final_report();
  end
  initial begin
    repeat (6000) @(posedge clock);
    failures++;
    final_report();
  end
endmodule // tb_nvm_page_erase_write_control
`default_nettype wire
